/* hdl/ptev_core.sv */
// core end: passes software accesses and peer task pulses onto the peripheral interface
`timescale 1ns/10ps
`default_nettype none
module ptev_core import ptev_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    ptev_if.core bus,
    input wire logic [11:0] swAddr,
    input wire logic [31:0] swWdata,
    input wire logic swWr,
    input wire logic swRd,
    output logic [31:0] swRdata,
    input wire logic [PTEV_NTASK-1:0] peerTask,
    output logic [PTEV_NEVT-1:0] peerEvent,
    output logic periphIrq
);
    // ************************************************************
    // bus and task toggles
    // ************************************************************
    logic [PTEV_NTASK-1:0] taskTgl_q;
    logic [PTEV_NEVT-1:0] evtSeen_q;

    // the peripheral drops pin-select writes while enabled; no ordering check is made here
    assign bus.addr = swAddr;
    assign bus.wdata = swWdata;
    assign bus.wr = swWr;
    assign bus.rd = swRd && !swWr;
    assign swRdata = bus.rdata;
    assign periphIrq = bus.irq;

    // a pulse is sent as a toggle; the peripheral finds each flip with one flop of history
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            taskTgl_q <= '0;
        end else begin
            taskTgl_q <= taskTgl_q ^ peerTask;
        end
    end
    assign bus.taskToggle = taskTgl_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            evtSeen_q <= '0;
        end else begin
            evtSeen_q <= bus.eventToggle;
        end
    end
    assign peerEvent = evtSeen_q ^ bus.eventToggle;
endmodule : ptev_core
`default_nettype wire

/* hdl/ptev_if.sv */
// interface: register bus plus task and event lines between the core and the peripheral
`timescale 1ns/10ps
`default_nettype none
interface ptev_if import ptev_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n
);
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic [PTEV_NTASK-1:0] taskToggle;
    logic [PTEV_NEVT-1:0] eventToggle;
    logic irq;
    modport periph (
        input addr, wdata, wr, rd, taskToggle,
        output rdata, eventToggle, irq
    );
    modport core (
        output addr, wdata, wr, rd, taskToggle,
        input rdata, eventToggle, irq
    );
endinterface : ptev_if
`default_nettype wire

/* hdl/ptev_periph.sv */
// peripheral end: task, event, shortcut, interrupt mask and example registers
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module ptev_periph import ptev_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    ptev_if.periph bus,
    input wire logic [PTEV_NEVT-1:0] hwEvent,
    output logic [PTEV_NTASK-1:0] taskFire,
    output logic [31:0] pinRoute,
    output logic [1:0] featureMode,
    output logic [7:0] periphId
);
    // ************************************************************
    // address decode
    // ************************************************************
    logic [PTEV_NTASK-1:0] taskPrev_q;
    logic enable_q;
    logic [31:0] exCtrl_q;
    logic [31:0] retain_q;
    logic [31:0] psel_q;
    logic [31:0] pinRoute_q;
    logic [2:0] pselDelay_q;
    logic [PTEV_NEVT-1:0] evtReg_q;
    logic [PTEV_NEVT-1:0] interrupt_enable_mask_q;
    logic [PTEV_NEVT-1:0] shorts_q;
    logic [PTEV_NEVT-1:0] evtToggle_q;
    logic [PTEV_NTASK-1:0] taskFire_q;
    logic [15:0] taskCount_q;
    logic [31:0] rdata_q;
    logic [PTEV_NTASK-1:0] taskWr;
    logic [PTEV_NTASK-1:0] taskHw;
    logic [PTEV_NTASK-1:0] taskNow;
    logic [PTEV_NEVT-1:0] evtHit;
    logic [PTEV_NEVT-1:0] evtWr;
    logic wrAt;

    assign periphId = PTEV_PERIPH_ID;

    // ************************************************************
    // tasks
    // ************************************************************
    // task toggles come from logic on this clock, so one flop of history finds each flip
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            taskPrev_q <= '0;
        end else begin
            taskPrev_q <= bus.taskToggle;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PTEV_NTASK; gi++) begin : gTask
            // byte offset bits [11:0] only: the window is 0x1000 bytes
            assign taskWr[gi] = bus.wr && bus.addr == PTEV_OFS_TASK0 + 12'(gi * 4)
                && bus.wdata[0];
            assign taskHw[gi] = bus.taskToggle[gi] != taskPrev_q[gi];
            // shortcut i links event i to task i
            assign taskNow[gi] = enable_q && (taskWr[gi] || taskHw[gi]
                || (shorts_q[gi] && evtHit[gi]));
        end
        for (gi = 0; gi < PTEV_NEVT; gi++) begin : gEvt
            assign evtHit[gi] = enable_q && hwEvent[gi];
            assign evtWr[gi] = bus.wr && bus.addr == PTEV_OFS_EVT0 + 12'(gi * 4);
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            taskFire_q <= '0;
            taskCount_q <= '0;
        end else begin
            taskFire_q <= taskNow;
            if (|taskNow) begin
                taskCount_q <= taskCount_q + 16'h0001;
            end
        end
    end
    assign taskFire = taskFire_q;

    // ************************************************************
    // events
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            evtReg_q <= '0;
            evtToggle_q <= '0;
        end else begin
            for (int i = 0; i < PTEV_NEVT; i++) begin
                // set wins over a software clear in the same cycle
                if (evtHit[i]) begin
                    evtReg_q[i] <= 1'b1;
                end else if (evtWr[i]) begin
                    evtReg_q[i] <= bus.wdata[0] ? 1'b1 : 1'b0;
                end
            end
            evtToggle_q <= evtToggle_q ^ evtHit;
        end
    end
    assign bus.eventToggle = evtToggle_q;
    assign bus.irq = |(evtReg_q & interrupt_enable_mask_q);

    // ************************************************************
    // configuration registers
    // ************************************************************
    assign wrAt = bus.wr;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_enable_mask_q <= '0;
            shorts_q <= '0;
        end else if (wrAt) begin
            unique case (bus.addr)
                PTEV_OFS_INTERRUPT_ENABLE_MASK: interrupt_enable_mask_q <= bus.wdata[PTEV_NEVT-1:0];
                PTEV_OFS_INTERRUPT_ENABLE_SET: interrupt_enable_mask_q <= interrupt_enable_mask_q | bus.wdata[PTEV_NEVT-1:0];
                PTEV_OFS_INTERRUPT_ENABLE_CLEAR: interrupt_enable_mask_q <= interrupt_enable_mask_q & ~bus.wdata[PTEV_NEVT-1:0];
                PTEV_OFS_SHORTS: shorts_q <= bus.wdata[PTEV_NEVT-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= 1'b0;
            exCtrl_q <= PTEV_EXCTRL_RESET;
        end else if (wrAt) begin
            if (bus.addr == PTEV_OFS_ENABLE) begin
                enable_q <= bus.wdata[0];
            end
            if (bus.addr == PTEV_OFS_EXCTRL) begin
                // the mode code 3 is unused, so it is refused and the field kept
                if (bus.wdata[1:0] != 2'h3) begin
                    exCtrl_q[PTEV_MODE_LSB +: PTEV_MODE_W] <= bus.wdata[1:0];
                end
                exCtrl_q[PTEV_OVR_BIT] <= bus.wdata[PTEV_OVR_BIT];
                if (bus.wdata[18:16] >= PTEV_RANGE_MIN && bus.wdata[18:16] <= PTEV_RANGE_MAX) begin
                    exCtrl_q[PTEV_RANGE_LSB +: PTEV_RANGE_W] <= bus.wdata[18:16];
                end
                exCtrl_q[PTEV_FREE_LSB +: PTEV_FREE_W] <= bus.wdata[31:24];
            end
        end
    end

    // retained register: only a power-on style reset clears it; this block has no deeper domain
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            retain_q <= '0;
        end else if (wrAt && bus.addr == PTEV_OFS_RETAIN) begin
            retain_q <= bus.wdata;
        end
    end

    // ************************************************************
    // pin select
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            psel_q <= PTEV_PSEL_RESET;
            pinRoute_q <= PTEV_PSEL_RESET;
            pselDelay_q <= '0;
        end else begin
            if (wrAt && bus.addr == PTEV_OFS_PSEL && !enable_q) begin
                psel_q <= bus.wdata;
                pselDelay_q <= PTEV_PSEL_DELAY;
            end else if (pselDelay_q != 3'h0) begin
                pselDelay_q <= pselDelay_q - 3'h1;
                if (pselDelay_q == 3'h1) begin
                    pinRoute_q <= psel_q;
                end
            end
        end
    end
    assign pinRoute = pinRoute_q;
    assign featureMode = exCtrl_q[PTEV_MODE_LSB +: PTEV_MODE_W];

    // ************************************************************
    // read path
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else if (bus.rd) begin
            rdata_q <= '0;
            for (int i = 0; i < PTEV_NEVT; i++) begin
                if (bus.addr == PTEV_OFS_EVT0 + 12'(i * 4)) begin
                    rdata_q <= {31'h0, evtReg_q[i]};
                end
            end
            unique case (bus.addr)
                PTEV_OFS_INTERRUPT_ENABLE_MASK,
                PTEV_OFS_INTERRUPT_ENABLE_SET,
                PTEV_OFS_INTERRUPT_ENABLE_CLEAR: rdata_q <= 32'(interrupt_enable_mask_q);
                PTEV_OFS_SHORTS: rdata_q <= 32'(shorts_q);
                PTEV_OFS_ENABLE: rdata_q <= {31'h0, enable_q};
                PTEV_OFS_PSEL: rdata_q <= psel_q;
                PTEV_OFS_EXCTRL: rdata_q <= exCtrl_q;
                PTEV_OFS_RETAIN: rdata_q <= retain_q;
                PTEV_OFS_STATUS: rdata_q <= {16'h0, periphId, 7'h0, bus.irq};
                PTEV_OFS_PINROUTE: rdata_q <= pinRoute_q;
                PTEV_OFS_TASKCNT: rdata_q <= {16'h0, taskCount_q};
                default: ;
            endcase
        end
    end
    assign bus.rdata = rdata_q;
endmodule : ptev_periph
`default_nettype wire

/* hdl/ptev_pkg.sv */
// package: register map, field layout and constants of the peripheral register bank
package ptev_pkg;
    localparam int PTEV_NTASK = 4;
    localparam int PTEV_NEVT = 4;
    localparam int PTEV_NPSEL = 8;
    // address window and peripheral identifier
    localparam logic [31:0] PTEV_PERIPH_REGION = 32'h4000_0000;
    localparam logic [31:0] PTEV_WINDOW_BYTES = 32'h0000_1000;
    localparam logic [31:0] PTEV_BASE_ADDR = 32'h4001_f000;
    localparam logic [7:0] PTEV_PERIPH_ID =
        8'((PTEV_BASE_ADDR - PTEV_PERIPH_REGION) / PTEV_WINDOW_BYTES);
    // byte offsets inside the window
    localparam logic [11:0] PTEV_OFS_TASK0 = 12'h000;
    localparam logic [11:0] PTEV_OFS_EVT0 = 12'h100;
    localparam logic [11:0] PTEV_OFS_SHORTS = 12'h200;
    localparam logic [11:0] PTEV_OFS_INTERRUPT_ENABLE_MASK = 12'h300;
    localparam logic [11:0] PTEV_OFS_INTERRUPT_ENABLE_SET = 12'h304;
    localparam logic [11:0] PTEV_OFS_INTERRUPT_ENABLE_CLEAR = 12'h308;
    localparam logic [11:0] PTEV_OFS_ENABLE = 12'h500;
    localparam logic [11:0] PTEV_OFS_PSEL = 12'h508;
    localparam logic [11:0] PTEV_OFS_EXCTRL = 12'h514;
    localparam logic [11:0] PTEV_OFS_RETAIN = 12'h518;
    localparam logic [11:0] PTEV_OFS_STATUS = 12'h51c;
    localparam logic [11:0] PTEV_OFS_PINROUTE = 12'h520;
    localparam logic [11:0] PTEV_OFS_TASKCNT = 12'h524;
    // reset values and field positions of the example control register
    localparam logic [31:0] PTEV_EXCTRL_RESET = 32'h0005_0002;
    localparam int PTEV_MODE_LSB = 0;
    localparam int PTEV_MODE_W = 2;
    localparam int PTEV_OVR_BIT = 4;
    localparam int PTEV_RANGE_LSB = 16;
    localparam int PTEV_RANGE_W = 3;
    localparam int PTEV_FREE_LSB = 24;
    localparam int PTEV_FREE_W = 8;
    localparam logic [2:0] PTEV_RANGE_MIN = 3'h2;
    localparam logic [2:0] PTEV_RANGE_MAX = 3'h7;
    localparam logic [31:0] PTEV_PSEL_RESET = 32'hffff_ffff;
    localparam logic [2:0] PTEV_PSEL_DELAY = 3'h4;
    typedef enum logic [1:0] {
        PTEV_MODE_OFF = 2'h0,
        normal_operation = 2'h1,
        extended_operation = 2'h2
    } ptev_mode_t;
endpackage : ptev_pkg

/* verification/ptev_regs_sva.sv */
// checker: register and event relations seen on the core to peripheral interface
`timescale 1ns/10ps
`default_nettype none
module ptev_regs_sva import ptev_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic [PTEV_NTASK-1:0] taskToggle,
    input wire logic [PTEV_NEVT-1:0] eventToggle,
    input wire logic irq
);
    // ****************
    // assertions
    // ****************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    unmapped_rd_zero_a: assert property (rd && addr == 12'hffc |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    task_rd_zero_a: assert property (rd && addr[11:8] == 4'h0 |=> rdata == 32'h0)
        else $error("task register read not zero");
    status_id_a: assert property (rd && addr == PTEV_OFS_STATUS |=>
        rdata[15:8] == 8'h1f && rdata[0] == $past(irq)) else $error("status word wrong");
    alias_read_a: assert property (rd && addr == PTEV_OFS_INTERRUPT_ENABLE_MASK ##1 !wr ##1 rd &&
        (addr == PTEV_OFS_INTERRUPT_ENABLE_SET || addr == PTEV_OFS_INTERRUPT_ENABLE_CLEAR) |=> rdata == $past(rdata, 2))
        else $error("alias read differs from main");
    evt_no_toggle_a: assert property (wr && addr[11:8] == 4'h1 |=> $stable(eventToggle))
        else $error("event write toggled event line");
    mask_clear_a: assert property (wr && addr == PTEV_OFS_INTERRUPT_ENABLE_CLEAR &&
        wdata == 32'hffff_ffff |=> !irq) else $error("irq after full mask clear");
    irq_cause_a: assert property ($rose(irq) |-> $past(wr) || $changed(eventToggle))
        else $error("irq rose without cause");
    reset_quiet_a: assert property (disable iff (1'b0) !rst_n |-> rdata == 32'h0 &&
        !irq && eventToggle == 4'h0 && taskToggle == 4'h0) else $error("reset values wrong");
endmodule : ptev_regs_sva
`default_nettype wire

/* verification/testbench.sv */
// testbench: both ends joined, driven from the software and peripheral user sides
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ptev_pkg::*;
    // ****************
    // stimulus and checks
    // ****************
    localparam logic [31:0] CTRL_MASK = 32'hff07_0013;
    logic core_clk, rst_n, swWr, swRd, periphIrq;
    logic [11:0] swAddr, a;
    logic [31:0] swWdata, swRdata, pinRoute, w, ctrl;
    logic [3:0] peerTask, hwEvent, taskFire, peerEvent;
    logic [1:0] featureMode;
    logic [7:0] periphId;
    int seed, n, failCount = 0, checked = 0;
    int fireCnt[4] = '{default: 0};
    int evtCnt[4] = '{default: 0};
    ptev_if u_ptev_if (.core_clk(core_clk), .rst_n(rst_n));
    ptev_core u_ptev_core (.core_clk(core_clk), .rst_n(rst_n), .bus(u_ptev_if),
        .swAddr(swAddr), .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata),
        .peerTask(peerTask), .peerEvent(peerEvent), .periphIrq(periphIrq));
    ptev_periph u_ptev_periph (.core_clk(core_clk), .rst_n(rst_n), .bus(u_ptev_if),
        .hwEvent(hwEvent), .taskFire(taskFire), .pinRoute(pinRoute),
        .featureMode(featureMode), .periphId(periphId));
    ptev_regs_sva u_ptev_regs_sva (.core_clk(core_clk), .rst_n(rst_n),
        .addr(u_ptev_if.addr), .wdata(u_ptev_if.wdata), .wr(u_ptev_if.wr), .rd(u_ptev_if.rd),
        .rdata(u_ptev_if.rdata), .taskToggle(u_ptev_if.taskToggle),
        .eventToggle(u_ptev_if.eventToggle), .irq(u_ptev_if.irq));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // pulses last one cycle, so one sample per edge counts each exactly once
    always @(posedge core_clk) begin
        for (int k = 0; k < 4; k++) begin
            fireCnt[k] += (taskFire[k] === 1'b1);
            evtCnt[k] += (peerEvent[k] === 1'b1);
        end
    end
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failCount++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic wrReg(input logic [11:0] ad, input logic [31:0] d);
        @(posedge core_clk);
        swWr <= 1'b1;
        swAddr <= ad;
        swWdata <= d;
        @(posedge core_clk);
        swWr <= 1'b0;
    endtask : wrReg
    task automatic rdChk(input string what, input logic [11:0] ad, input logic [31:0] e,
        input logic [31:0] m);
        @(posedge core_clk);
        swRd <= 1'b1;
        swAddr <= ad;
        @(posedge core_clk);
        swRd <= 1'b0;
        #1 chk(what, e & m, swRdata & m);
    endtask : rdChk
    task automatic pulse(input bit peer, input int i);
        @(posedge core_clk);
        if (peer) peerTask <= 4'h1 << i;
        else hwEvent <= 4'h1 << i;
        @(posedge core_clk);
        peerTask <= 4'h0;
        hwEvent <= 4'h0;
        repeat (8) @(posedge core_clk);
        #1;
    endtask : pulse
    // illegal mode or range codes leave the register as it was
    function automatic logic [31:0] expCtrl(input logic [31:0] old, input logic [31:0] v);
        if (v[1:0] == 2'h3 || v[18:16] < PTEV_RANGE_MIN) return old;
        return v;
    endfunction : expCtrl
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20000) @(posedge core_clk);
        failCount++;
        give_verdict();
    end
    initial begin
        seed = 55429;
        {rst_n, swWr, swRd, swAddr, swWdata, peerTask, hwEvent} = '0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        rdChk("ctrl", PTEV_OFS_EXCTRL, PTEV_EXCTRL_RESET, CTRL_MASK);
        chk("id", 32'h1f, 32'(periphId));
        rdChk("status", PTEV_OFS_STATUS, 32'h1f00, 32'hff01);
        wrReg(12'hffc, 32'hffff_ffff);
        rdChk("unmapped", 12'hffc, 32'h0, 32'hffff_ffff);
        ctrl = PTEV_EXCTRL_RESET;
        for (int m = 0; m < 6; m++) begin
            w = $random(seed);
            w[18:16] = (m == 5) ? 3'h7 : 3'h2;
            w[1:0] = 2'(m % 3);
            w[PTEV_OVR_BIT] = (m == 5);
            if (m == 3) w = {ctrl[31:2], 2'h3};
            if (m == 4) w = {ctrl[31:19], 3'h1, ctrl[15:0]};
            ctrl = expCtrl(ctrl, w);
            wrReg(PTEV_OFS_EXCTRL, w);
            rdChk("ctrl", PTEV_OFS_EXCTRL, ctrl, CTRL_MASK);
            chk("mode", 32'(ctrl[1:0]), 32'(featureMode));
        end
        n = fireCnt[0];
        wrReg(PTEV_OFS_TASK0, 32'h1);
        pulse(1'b1, 0);
        pulse(1'b0, 0);
        chk("fire off", n, fireCnt[0]);
        rdChk("evt off", PTEV_OFS_EVT0, 32'h0, 32'h1);
        wrReg(PTEV_OFS_ENABLE, 32'h1);
        for (int i = 0; i < 4; i++) begin
            a = 12'(PTEV_OFS_TASK0 + 4 * i);
            n = fireCnt[i];
            wrReg(a, 32'h1);
            wrReg(a, 32'h0);
            rdChk("task rd", a, 32'h0, 32'hffff_ffff);
            chk("fire sw", n + 1, fireCnt[i]);
            pulse(1'b1, i);
            chk("fire peer", n + 2, fireCnt[i]);
        end
        w = $random(seed);
        wrReg(PTEV_OFS_INTERRUPT_ENABLE_SET, w | 32'h1);
        wrReg(PTEV_OFS_INTERRUPT_ENABLE_CLEAR, ~32'h1);
        rdChk("mask", PTEV_OFS_INTERRUPT_ENABLE_MASK, 32'h1, 32'hf);
        rdChk("mask set", PTEV_OFS_INTERRUPT_ENABLE_SET, 32'h1, 32'hf);
        rdChk("mask clr", PTEV_OFS_INTERRUPT_ENABLE_CLEAR, 32'h1, 32'hf);
        for (int i = 0; i < 4; i++) begin
            a = 12'(PTEV_OFS_EVT0 + 4 * i);
            n = evtCnt[i];
            pulse(1'b0, i);
            rdChk("evt", a, 32'h1, 32'h1);
            chk("irq", 32'(i == 0), 32'(periphIrq));
            pulse(1'b0, i);
            chk("evt cnt", n + 2, evtCnt[i]);
            wrReg(a, 32'h0);
            rdChk("evt clr", a, 32'h0, 32'h1);
            wrReg(a, 32'h1);
            rdChk("evt sw", a, 32'h1, 32'h1);
            chk("evt cnt", n + 2, evtCnt[i]);
            wrReg(a, 32'h0);
        end
        pulse(1'b0, 0);
        wrReg(PTEV_OFS_INTERRUPT_ENABLE_CLEAR, 32'hffff_ffff);
        wrReg(PTEV_OFS_SHORTS, 32'hf);
        n = fireCnt[2];
        pulse(1'b0, 2);
        chk("shortcut", n + 1, fireCnt[2]);
        // four software writes, four peer toggles and one shortcut while enabled
        rdChk("task cnt", PTEV_OFS_TASKCNT, 32'h9, 32'hffff);
        w = $random(seed);
        wrReg(PTEV_OFS_PSEL, w);
        repeat (6) @(posedge core_clk);
        #1 chk("route run", PTEV_PSEL_RESET, pinRoute);
        wrReg(PTEV_OFS_ENABLE, 32'h0);
        wrReg(PTEV_OFS_PSEL, w);
        repeat (3) @(posedge core_clk);
        #1 chk("route early", PTEV_PSEL_RESET, pinRoute);
        @(posedge core_clk);
        #1 chk("route", w, pinRoute);
        rdChk("route reg", PTEV_OFS_PINROUTE, w, 32'hffff_ffff);
        w = $random(seed);
        wrReg(PTEV_OFS_RETAIN, w);
        rdChk("retain", PTEV_OFS_RETAIN, w, 32'hffff_ffff);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rdChk("ctrl", PTEV_OFS_EXCTRL, PTEV_EXCTRL_RESET, CTRL_MASK);
        chk("route rst", PTEV_PSEL_RESET, pinRoute);
        rdChk("retain rst", PTEV_OFS_RETAIN, 32'h0, 32'hffff_ffff);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
